// ===== design/fifo_pins_pkg.sv
// Shared constants for the pin-level FIFO device and its bus controller
package fifo_pins_pkg;
  // Data path and storage
  localparam int DATA_W = 18;
  localparam int DEPTH_DEF = 8192;
  // Offset register contents after reset (almost-empty, almost-full)
  localparam logic [17:0] AE_OFF_RST = 18'h0007F;
  localparam logic [17:0] AF_OFF_RST = 18'h0007F;
  // Controller register byte addresses
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_WDATA = 4'h4;
  localparam logic [3:0] ADR_RDATA = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hC;
  // Control register fields (levels in 4:0, self-clearing strobes above)
  localparam int CTRL_SYNC_SEL = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_OE = 2;
  localparam int CTRL_CASCADE = 3;
  localparam int CTRL_FIRST = 4;
  localparam int CTRL_LVL_W = 5;
  localparam int CTRL_RESET = 8;
  localparam int CTRL_RETX = 9;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // Status register fields
  localparam int STAT_EMPTY_N = 0;
  localparam int STAT_AE_N = 1;
  localparam int STAT_HALF = 2;
  localparam int STAT_AF_N = 3;
  localparam int STAT_FULL_N = 4;
  localparam int STAT_RD_CASC_N = 5;
endpackage

// ===== design/fifo_pins_if.sv
// Pin bundle joining the FIFO device and the controller that drives it
`timescale 1ns/100ps
interface fifo_pins_if;
  logic [fifo_pins_pkg::DATA_W-1:0] din;
  logic [fifo_pins_pkg::DATA_W-1:0] q;
  logic q_oe;
  logic write_en_n;
  logic read_en_n;
  logic output_en_n;
  logic offset_load_n;
  logic first_load_retransmit;
  logic device_reset_n;
  logic flag_sync_select;
  logic cascade_mode;
  logic write_cascade_in;
  logic read_cascade_in;
  logic read_cascade_out;
  logic half_full_or_write_cascade_out;
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_empty_flag_n;
  logic almost_full_flag_n;

  modport device (
    input din, write_en_n, read_en_n, output_en_n, offset_load_n,
    input first_load_retransmit, device_reset_n, flag_sync_select, cascade_mode,
    input write_cascade_in, read_cascade_in,
    output q, q_oe, read_cascade_out, half_full_or_write_cascade_out,
    output empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n
  );
  modport host (
    output din, write_en_n, read_en_n, output_en_n, offset_load_n,
    output first_load_retransmit, device_reset_n, flag_sync_select, cascade_mode,
    output write_cascade_in, read_cascade_in,
    input q, q_oe, read_cascade_out, half_full_or_write_cascade_out,
    input empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n
  );
endinterface

// ===== design/fifo_device.sv
// FIFO device end: storage, pointers, flags, offset register, retransmit
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Read enable low, not empty: next word out
// - Load strobe low: reads return offset register
// - Half-full pin, or write cascade out when chained
// - Empty flag low when no words, read side
// - Full flag low at capacity, write side
// - Almost-empty low within programmed offset of empty
// - Almost-empty registered or asynchronous per select
// - Almost-full low within programmed offset of full
// - Almost-full registered or asynchronous per select
// - Load strobe low: data pins access offset register
// - Chain: first device first-load low, others high
// - Standalone or wide: first-load held low
// - Standalone: strobing first-load pin retransmits
// - Chain expansion links; held low when unchained
// - Reset empties device, clears pointers
// - Controller resets device before first access
// - Output enable low drives data, else released
// - Write enable low, not full: word stored
// - Load strobe low: writes load offset register
module fifo_device #(
  parameter int DEPTH = fifo_pins_pkg::DEPTH_DEF
)(
  input wire logic i_mclk,
  input wire logic i_rst,
  fifo_pins_if.device pins,
  output logic [$clog2(DEPTH):0] o_fill_count
);
  localparam int W = fifo_pins_pkg::DATA_W;
  localparam int PW = $clog2(DEPTH);

  typedef logic [PW-1:0] ptr_t;
  typedef logic [PW:0] cnt_t;

  localparam cnt_t FULL_CNT = cnt_t'(DEPTH);
  localparam cnt_t HALF_CNT = cnt_t'(DEPTH / 2);

  typedef struct packed {
    ptr_t wr_ptr;
    ptr_t rd_ptr;
    cnt_t count;
    cnt_t span;
    logic [W-1:0] q;
    logic [W-1:0] ae_off;
    logic [W-1:0] af_off;
    logic wr_to_af;
    logic rd_from_af;
    logic empty_n;
    logic full_n;
    logic ae_n;
    logic af_n;
    logic half_out;
    logic rd_casc_n;
    logic q_oe;
    logic rewind_prev;
  } state_s;

  state_s st;
  state_s next_st;
  logic [W-1:0] mem [DEPTH];
  logic wr_ok;
  logic rd_ok;
  logic rewind_go;
  logic load_active;

  // Storage depth must be a power of two so pointers wrap for free
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic state_s reset_state();
    state_s s;
    s = '0;
    s.ae_off = fifo_pins_pkg::AE_OFF_RST;
    s.af_off = fifo_pins_pkg::AF_OFF_RST;
    s.ae_n = 1'b0;
    s.af_n = 1'b1;
    s.full_n = 1'b1;
    s.half_out = 1'b1;
    s.rd_casc_n = 1'b1;
    return s;
  endfunction

  // Low when the fill level is at or below the almost-empty offset
  function automatic logic almost_empty_n(input cnt_t cnt, input logic [W-1:0] off);
    return !(W'(cnt) <= off);
  endfunction

  // Low when the free space is at or below the almost-full offset
  function automatic logic almost_full_n(input cnt_t cnt, input logic [W-1:0] off);
    return !(W'(FULL_CNT - cnt) <= off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    next_st = st;
    load_active = !pins.offset_load_n;
    // Retransmit only exists when the device is not part of a chain
    rewind_go = !pins.cascade_mode && pins.first_load_retransmit && !st.rewind_prev;
    wr_ok = !pins.write_en_n && !load_active && st.count != FULL_CNT && !rewind_go;
    rd_ok = !pins.read_en_n && !load_active && st.count != '0 && !rewind_go;
    next_st.rewind_prev = pins.first_load_retransmit;
    next_st.q_oe = !pins.output_en_n;
    next_st.rd_casc_n = 1'b1;

    // Offset register access pairs words: almost-empty first, then almost-full
    if (load_active)
    begin
      if (!pins.write_en_n)
      begin
        if (st.wr_to_af)
          next_st.af_off = pins.din;
        else
          next_st.ae_off = pins.din;
        next_st.wr_to_af = !st.wr_to_af;
      end
      if (!pins.read_en_n)
      begin
        next_st.q = st.rd_from_af ? st.af_off : st.ae_off;
        next_st.rd_from_af = !st.rd_from_af;
      end
    end
    else
    begin
      next_st.wr_to_af = 1'b0;
      next_st.rd_from_af = 1'b0;
    end

    // Data path: pointer moves and fill level
    if (rewind_go)
    begin
      // Rewind to the oldest word still held since reset
      next_st.rd_ptr = st.wr_ptr - st.span[PW-1:0];
      next_st.count = st.span;
    end
    else
    begin
      if (wr_ok)
      begin
        next_st.wr_ptr = st.wr_ptr + 1'b1;
        if (st.span != FULL_CNT)
          next_st.span = st.span + 1'b1;
      end
      if (rd_ok)
      begin
        next_st.q = mem[st.rd_ptr];
        next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      if (wr_ok && !rd_ok)
        next_st.count = st.count + 1'b1;
      else if (rd_ok && !wr_ok)
        next_st.count = st.count - 1'b1;
    end

    // Flags follow the updated level; one clock serves both port sides
    next_st.empty_n = next_st.count != '0;
    next_st.full_n = next_st.count != FULL_CNT;
    next_st.ae_n = almost_empty_n(next_st.count, next_st.ae_off);
    next_st.af_n = almost_full_n(next_st.count, next_st.af_off);

    // Shared pin: half-full level alone, or a one-cycle hand-on pulse in a chain
    if (pins.cascade_mode)
      next_st.half_out = !(wr_ok && next_st.count == FULL_CNT);
    else
      next_st.half_out = !(next_st.count > HALF_CNT);
    if (pins.cascade_mode && rd_ok && next_st.count == '0)
      next_st.rd_casc_n = 1'b0;

    // Synchronous device reset wins over every access
    if (!pins.device_reset_n)
    begin
      next_st = reset_state();
      // Output drive has its own pin, so a device reset leaves it alone
      next_st.q_oe = !pins.output_en_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      st <= reset_state();
    else
      st <= next_st;
  end

  // Storage array has no reset; the pointers alone define what is valid
  always_ff @(posedge i_mclk)
  begin
    if (wr_ok && pins.device_reset_n)
      mem[st.wr_ptr] <= pins.din;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive

  // With the select high the almost flags are decoded from the registered level, changing on the same edge as the registered flags
  always_comb
  begin
    if (pins.flag_sync_select)
    begin
      pins.almost_empty_flag_n = almost_empty_n(st.count, st.ae_off);
      pins.almost_full_flag_n = almost_full_n(st.count, st.af_off);
    end
    else
    begin
      pins.almost_empty_flag_n = st.ae_n;
      pins.almost_full_flag_n = st.af_n;
    end
  end

  assign pins.q = st.q;
  assign pins.q_oe = st.q_oe;
  assign pins.empty_flag_n = st.empty_n;
  assign pins.full_flag_n = st.full_n;
  assign pins.half_full_or_write_cascade_out = st.half_out;
  assign pins.read_cascade_out = st.rd_casc_n;
  assign o_fill_count = st.count;
endmodule // fifo_device

// ===== design/fifo_host.sv
// Controller end: classic Wishbone slave that drives the FIFO pins
`timescale 1ns/100ps
module fifo_host (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  fifo_pins_if.host pins
);
  localparam int W = fifo_pins_pkg::DATA_W;

  typedef enum logic [1:0] {H_IDLE, H_RD_TAKE, H_RD_WAIT} host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [fifo_pins_pkg::CTRL_LVL_W-1:0] ctrl;
    logic [W-1:0] din;
    logic wr_n;
    logic rd_n;
    logic dev_rst_n;
    logic rewind;
    logic ack;
    logic [31:0] dat;
  } state_s;

  state_s st;
  state_s next_st;
  logic req;

  function automatic state_s reset_state();
    state_s s;
    s = '0;
    s.state = H_IDLE;
    s.ctrl = fifo_pins_pkg::CTRL_RST;
    s.wr_n = 1'b1;
    s.rd_n = 1'b1;
    s.dev_rst_n = 1'b0; // Power-up always resets the device first
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode and pin sequencing

  always_comb
  begin
    next_st = st;
    req = i_wb_cyc && i_wb_stb && !st.ack;
    next_st.ack = 1'b0;
    next_st.wr_n = 1'b1;
    next_st.rd_n = 1'b1;
    next_st.dev_rst_n = 1'b1;
    next_st.rewind = 1'b0;
    unique case (st.state)
      H_IDLE:
      begin
        if (req && i_wb_we)
        begin
          next_st.ack = 1'b1;
          if (i_wb_adr == fifo_pins_pkg::ADR_CTRL)
          begin
            if (i_wb_sel[0])
              next_st.ctrl = i_wb_dat[fifo_pins_pkg::CTRL_LVL_W-1:0];
            if (i_wb_sel[1])
            begin
              next_st.dev_rst_n = !i_wb_dat[fifo_pins_pkg::CTRL_RESET];
              next_st.rewind = i_wb_dat[fifo_pins_pkg::CTRL_RETX];
            end
          end
          else if (i_wb_adr == fifo_pins_pkg::ADR_WDATA)
          begin
            // Word goes out whatever the full flag says; the device drops it when full
            next_st.din = i_wb_dat[W-1:0];
            next_st.wr_n = 1'b0;
          end
        end
        else if (req)
        begin
          next_st.dat = '0;
          if (i_wb_adr == fifo_pins_pkg::ADR_RDATA)
          begin
            next_st.ack = 1'b0;
            next_st.rd_n = 1'b0;
            next_st.state = H_RD_TAKE;
          end
          else
          begin
            next_st.ack = 1'b1;
            if (i_wb_adr == fifo_pins_pkg::ADR_CTRL)
              next_st.dat = 32'(st.ctrl);
            else if (i_wb_adr == fifo_pins_pkg::ADR_STATUS)
            begin
              next_st.dat[fifo_pins_pkg::STAT_EMPTY_N] = pins.empty_flag_n;
              next_st.dat[fifo_pins_pkg::STAT_AE_N] = pins.almost_empty_flag_n;
              next_st.dat[fifo_pins_pkg::STAT_HALF] = pins.half_full_or_write_cascade_out;
              next_st.dat[fifo_pins_pkg::STAT_AF_N] = pins.almost_full_flag_n;
              next_st.dat[fifo_pins_pkg::STAT_FULL_N] = pins.full_flag_n;
              next_st.dat[fifo_pins_pkg::STAT_RD_CASC_N] = pins.read_cascade_out;
            end
          end
        end
      end
      // Device takes the read and updates q at this edge; the host latches q one edge later
      H_RD_TAKE:
        next_st.state = H_RD_WAIT;
      H_RD_WAIT:
      begin
        next_st.dat = 32'(pins.q);
        next_st.ack = 1'b1;
        next_st.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      st <= reset_state();
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin and bus drive

  assign pins.din = st.din;
  assign pins.write_en_n = st.wr_n;
  assign pins.read_en_n = st.rd_n;
  assign pins.output_en_n = !st.ctrl[fifo_pins_pkg::CTRL_OE];
  assign pins.offset_load_n = !st.ctrl[fifo_pins_pkg::CTRL_LOAD];
  assign pins.flag_sync_select = st.ctrl[fifo_pins_pkg::CTRL_SYNC_SEL];
  assign pins.cascade_mode = st.ctrl[fifo_pins_pkg::CTRL_CASCADE];
  // First-load level in a chain, otherwise low apart from retransmit strobes
  assign pins.first_load_retransmit = st.ctrl[fifo_pins_pkg::CTRL_CASCADE]
      ? st.ctrl[fifo_pins_pkg::CTRL_FIRST] : st.rewind;
  // No chain partner here, so the expansion inputs stay low
  assign pins.write_cascade_in = 1'b0;
  assign pins.read_cascade_in = 1'b0;
  assign pins.device_reset_n = st.dev_rst_n;
  assign o_wb_dat = st.dat;
  assign o_wb_ack = st.ack;
endmodule // fifo_host

// ===== test/fifo_pins_asserts.sv
// Concurrent checks on the pins between the FIFO device and its controller
`timescale 1ns/100ps
module fifo_pins_asserts (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [fifo_pins_pkg::DATA_W-1:0] q,
  input wire logic q_oe,
  input wire logic write_en_n,
  input wire logic read_en_n,
  input wire logic output_en_n,
  input wire logic offset_load_n,
  input wire logic first_load_retransmit,
  input wire logic device_reset_n,
  input wire logic flag_sync_select,
  input wire logic cascade_mode,
  input wire logic half_full_or_write_cascade_out,
  input wire logic read_cascade_out,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Edges without a device reset or a rewind; those move the read pointer and the count at once
  sequence s_quiet;
    device_reset_n && !first_load_retransmit;
  endsequence
  sequence s_load_edge;
    s_quiet ##0 !offset_load_n;
  endsequence
  property p_hold_q;
    s_quiet ##0 read_en_n |=> $stable(q);
  endproperty
  property p_oe;
    1'b1 |=> q_oe == !$past(output_en_n);
  endproperty
  property p_fill;
    s_quiet ##0 (!empty_flag_n && read_en_n && !write_en_n && offset_load_n) |=> empty_flag_n;
  endproperty
  property p_empty_hold;
    s_quiet ##0 (!empty_flag_n && write_en_n) |=> !empty_flag_n;
  endproperty
  property p_full_hold;
    s_quiet ##0 (!full_flag_n && read_en_n) |=> !full_flag_n;
  endproperty
  property p_reset;
    !device_reset_n |=> !empty_flag_n && full_flag_n && q == '0;
  endproperty
  property p_ae_async;
    flag_sync_select && !empty_flag_n |-> !almost_empty_flag_n;
  endproperty
  property p_af_async;
    flag_sync_select && !full_flag_n |-> !almost_full_flag_n;
  endproperty
  // The pin was formed under last cycle's mode, so both cycles must be unchained
  property p_half;
    !cascade_mode && !$past(cascade_mode) && !full_flag_n |-> !half_full_or_write_cascade_out;
  endproperty
  // Chain hand-on pulses mark exactly the write that fills and the read that empties
  property p_chain_write_out;
    $past(cascade_mode) |-> ((!half_full_or_write_cascade_out) == $fell(full_flag_n));
  endproperty
  property p_chain_read_out;
    $past(cascade_mode) && $past(device_reset_n) |-> ((!read_cascade_out) == $fell(empty_flag_n));
  endproperty
  // Offset traffic must leave the word count alone
  property p_load;
    s_load_edge |=> $stable(empty_flag_n) && $stable(full_flag_n);
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_hold_q: assert property (p_hold_q) else $error("q moved without a read");
  a_oe: assert property (p_oe) else $error("q drive not following enable");
  a_fill: assert property (p_fill) else $error("empty kept after write");
  a_empty_hold: assert property (p_empty_hold) else $error("empty left alone");
  a_full_hold: assert property (p_full_hold) else $error("full left alone");
  a_reset: assert property (p_reset) else $error("device reset not empty");
  a_ae_async: assert property (p_ae_async) else $error("almost empty high");
  a_af_async: assert property (p_af_async) else $error("almost full high");
  a_half: assert property (p_half) else $error("half full high when full");
  a_chain_write_out: assert property (p_chain_write_out) else $error("write hand-on pulse wrong");
  a_chain_read_out: assert property (p_chain_read_out) else $error("read hand-on pulse wrong");
  a_load: assert property (p_load) else $error("offset access moved count");
endmodule // fifo_pins_asserts

// ===== test/tb_top.sv
// Self-checking bench: controller and device joined over the pin interface
`timescale 1ns/100ps
module tb_top;
  // Short depth keeps fills quick yet above the reset offsets
  localparam int D = 256;
  logic mclk;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic [3:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [31:0] r;
  logic [17:0] v;
  logic [17:0] m [D];
  logic [$clog2(D):0] fill;
  int seed;
  int fail_count;
  int n_tests;
  fifo_pins_if pif();
  // Data pins float whenever the device is not driving them
  wire [17:0] q_bus;
  assign q_bus = pif.q_oe ? pif.q : 'z;
  fifo_host fifo_host_i (
    .i_mclk(mclk),
    .i_rst(rst),
    .i_wb_cyc(cyc),
    .i_wb_stb(stb),
    .i_wb_we(we),
    .i_wb_adr(adr),
    .i_wb_dat(wdat),
    .i_wb_sel(4'hF),
    .o_wb_dat(rdat),
    .o_wb_ack(ack),
    .pins(pif.host)
  );
  fifo_device #(.DEPTH(D)) fifo_device_i (
    .i_mclk(mclk),
    .i_rst(rst),
    .pins(pif.device),
    .o_fill_count(fill)
  );
  fifo_pins_asserts fifo_pins_asserts_i (
    .i_mclk(mclk),
    .i_rst(rst),
    .q(pif.q),
    .q_oe(pif.q_oe),
    .write_en_n(pif.write_en_n),
    .read_en_n(pif.read_en_n),
    .output_en_n(pif.output_en_n),
    .offset_load_n(pif.offset_load_n),
    .first_load_retransmit(pif.first_load_retransmit),
    .device_reset_n(pif.device_reset_n),
    .flag_sync_select(pif.flag_sync_select),
    .cascade_mode(pif.cascade_mode),
    .half_full_or_write_cascade_out(pif.half_full_or_write_cascade_out),
    .read_cascade_out(pif.read_cascade_out),
    .empty_flag_n(pif.empty_flag_n),
    .full_flag_n(pif.full_flag_n),
    .almost_empty_flag_n(pif.almost_empty_flag_n),
    .almost_full_flag_n(pif.almost_full_flag_n)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits for ack with no assumed latency, a hang is the watchdog's
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1)
      @(posedge mclk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  // Status word expected for n words held and the given offsets
  task automatic st(input int n, input int ae, input int af);
    wb(1'b0, fifo_pins_pkg::ADR_STATUS, 32'h0);
    chk(r, {26'h0, 1'b1, n != D, (D - n) > af, n <= D / 2, n > ae, n != 0});
  endtask
  task automatic rdc(input logic [17:0] e);
    wb(1'b0, fifo_pins_pkg::ADR_RDATA, 32'h0);
    chk(r, {14'h0, e});
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Watchdog sized well beyond the few thousand cycles the sequence needs
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
  initial
  begin
    seed = 41;
    fail_count = 0;
    n_tests = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, q_bus === {18{1'bz}}}, 32'h1);
    st(0, 127, 127);
    wb(1'b0, 4'h1, 32'h0);
    chk(r, 32'h0);
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'h6);
    chk({31'h0, pif.q_oe}, 32'h1);
    wb(1'b1, fifo_pins_pkg::ADR_WDATA, 32'h2);
    wb(1'b1, fifo_pins_pkg::ADR_WDATA, 32'h3);
    rdc(18'h2);
    rdc(18'h3);
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'h4);
    // Fill past capacity; corner words of all ones and all zeros early on
    for (int i = 0; i <= D; i++)
    begin
      v = (i == 3) ? 18'h3FFFF : (i == 4) ? 18'h0 : 18'($random(seed));
      if (i < D)
        m[i] = v;
      wb(1'b1, fifo_pins_pkg::ADR_WDATA, {14'h0, v});
      st((i < D) ? i + 1 : D, 2, 3);
    end
    chk(32'(fill), 32'(D));
    for (int i = 0; i < 10; i++)
    begin
      rdc(m[i]);
      st(D - 1 - i, 2, 3);
    end
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'h204);
    st(D, 2, 3);
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'h5);
    st(D, 2, 3);
    rdc(m[0]);
    rdc(m[1]);
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'h105);
    st(0, 127, 127);
    rdc(18'h0);
    // Chained as first device; the checker watches both hand-on pulses
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'hC);
    chk({31'h0, pif.first_load_retransmit}, 32'h0);
    wb(1'b1, fifo_pins_pkg::ADR_WDATA, 32'h5);
    rdc(18'h5);
    for (int i = 0; i < D; i++)
      wb(1'b1, fifo_pins_pkg::ADR_WDATA, 32'(i));
    // Full in a chain: pin idles high, almost-full and full low, rest high
    wb(1'b0, fifo_pins_pkg::ADR_STATUS, 32'h0);
    chk(r, 32'h27);
    wb(1'b1, fifo_pins_pkg::ADR_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, q_bus === {18{1'bz}}}, 32'h1);
    conclude();
  end
endmodule // tb_top
